// ---- verilog/intc_pkg.sv ----
/*
  constants, register map and bus carriers of the two-level interrupt controller.
  assumes an AXI4-Lite master with 8-bit byte addresses and a core that acks vectors.
*/
// Contract
// - two request levels, high vectors to 0008h, low vectors to 0018h
// - an enabled high request preempts a low service routine in progress
// - each source has a flag, an enable and a priority selection
// - priority levels work only while priority_levels_enable is set; resets cleared
// - with priority, high enable permits all high-priority sources
// - with priority, low sources need both high and low enables
// - flag, enable and global enables set redirect at once to the level's vector
// - in compatibility mode priority selections are ignored
// - compatibility: bit 6 gates peripheral sources, bit 7 gates every source
// - compatibility mode always vectors to 0008h
// - accepting a request clears the matching global enable
// - no low request is accepted during high service
// - on accept the core pushes return address and loads the vector
// - return op leaves service and sets the enable cleared on entry
// - pin event to vector latency is fixed, whatever the interrupted op
// - flags set on events regardless of any enable
// - pin edge select: one means rising, zero means falling
package intc_pkg;
  localparam int NSRC = 8;
  localparam int NEXT = 4;
  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW  = 16'h0018;
  localparam logic [7:0] OFF_RESET_CTRL = 8'h00;
  localparam logic [7:0] OFF_INT_CTRL   = 8'h04;
  localparam logic [7:0] OFF_FLAGS      = 8'h08;
  localparam logic [7:0] OFF_ENABLES    = 8'h0C;
  localparam logic [7:0] OFF_PRIORITY   = 8'h10;
  localparam logic [7:0] OFF_EDGE       = 8'h14;
  localparam logic [7:0] OFF_STATUS     = 8'h18;
  localparam int BIT_PRIO_EN = 7;
  localparam int BIT_GIE_H   = 7;
  localparam int BIT_GIE_L   = 6;
  localparam logic [7:0] PERIPH_MASK = 8'hF0;
  localparam logic [7:0] RST_PRIO    = 8'hFF;
  localparam logic [3:0] RST_EDGE    = 4'hF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_REQ  = 2'b10
  } ctl_state_t;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;
endpackage

// ---- verilog/two_level_intc.sv ----
/*
  two-level interrupt controller with an AXI4-Lite register slave.
  assumes the core holds core_ack_in for one cycle when it takes a vector,
  and pulses return_op_in for one cycle on the return-from-service op.
*/
`timescale 1ns/1ps
module two_level_intc
  import intc_pkg::*;
(
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire axi_req_t         axi_req_in,
  output axi_rsp_t              axi_rsp_out,
  input  wire logic [NEXT-1:0]  ext_pin_in,
  input  wire logic [NEXT-1:0]  periph_event_in,
  input  wire logic             core_ack_in,
  input  wire logic             return_op_in,
  output logic                  irq_req_out,
  output logic [15:0]           vector_out,
  output logic                  wake_out
);

  typedef struct packed {
    ctl_state_t       st;
    logic             priority_levels_enable;
    logic             high_level_global_enable;
    logic             low_level_global_enable;
    logic [NSRC-1:0]  flag;
    logic [NSRC-1:0]  en;
    logic [NSRC-1:0]  pri;
    logic [NEXT-1:0]  edge_sel;
    logic [NEXT-1:0]  pin_prev;
    logic             hi_act;
    logic             lo_act;
    logic             req;
    logic [15:0]      vec;
    logic             vec_hi;
    logic             wake;
    logic             aw_have;
    logic             w_have;
    logic [7:0]       awaddr;
    logic [7:0]       wdata;
    logic             wlane0;
    axi_rsp_t         rsp;
  } state_t;

  state_t          q;
  state_t          d;
  logic [NSRC-1:0] ev;
  logic [NSRC-1:0] clr;
  logic [NSRC-1:0] live;
  logic            hi_pend;
  logic            lo_pend;
  logic [7:0]      rd;
  logic            rd_ok;
  logic            wr_ok;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr[7:2] == off[7:2];
  endfunction

  always_comb begin
    d       = q;
    ev      = '0;
    clr     = '0;
    rd      = '0;
    rd_ok   = 1'b1;
    wr_ok   = 1'b1;
    hi_pend = 1'b0;
    lo_pend = 1'b0;

    // flags latch regardless of any enable
    for (int i = 0; i < NEXT; i++) begin
      if (q.edge_sel[i]) begin
        ev[i] = ext_pin_in[i] & ~q.pin_prev[i];
      end else begin
        ev[i] = ~ext_pin_in[i] & q.pin_prev[i];
      end
    end
    ev[NSRC-1:NEXT] = periph_event_in;
    d.pin_prev      = ext_pin_in;

    live = q.flag & q.en;
    if (q.priority_levels_enable) begin
      hi_pend = q.high_level_global_enable & |(live & q.pri);
      lo_pend = q.high_level_global_enable & q.low_level_global_enable
                & |(live & ~q.pri) & ~q.hi_act;
    end else begin
      // compatibility: priority ignored, bit 6 gates peripherals
      hi_pend = q.high_level_global_enable
                & |(live & (~PERIPH_MASK | {NSRC{q.low_level_global_enable}}));
    end
    d.wake = |live;

    // register writes, taken once both address and data are held
    if (axi_req_in.awvalid && q.rsp.awready) begin
      d.aw_have     = 1'b1;
      d.awaddr      = axi_req_in.awaddr;
      d.rsp.awready = 1'b0;
    end
    if (axi_req_in.wvalid && q.rsp.wready) begin
      d.w_have     = 1'b1;
      d.wdata      = axi_req_in.wdata[7:0];
      d.wlane0     = axi_req_in.wstrb[0];
      d.rsp.wready = 1'b0;
    end
    if (d.aw_have && d.w_have && !q.rsp.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      if (hit(d.awaddr, OFF_RESET_CTRL)) begin
        if (d.wlane0) begin
          d.priority_levels_enable = d.wdata[BIT_PRIO_EN];
        end
      end else if (hit(d.awaddr, OFF_INT_CTRL)) begin
        if (d.wlane0) begin
          d.high_level_global_enable = d.wdata[BIT_GIE_H];
          d.low_level_global_enable  = d.wdata[BIT_GIE_L];
        end
      end else if (hit(d.awaddr, OFF_FLAGS)) begin
        if (d.wlane0) begin
          clr = d.wdata; // write one to clear
        end
      end else if (hit(d.awaddr, OFF_ENABLES)) begin
        if (d.wlane0) begin
          d.en = d.wdata;
        end
      end else if (hit(d.awaddr, OFF_PRIORITY)) begin
        if (d.wlane0) begin
          d.pri = d.wdata;
        end
      end else if (hit(d.awaddr, OFF_EDGE)) begin
        if (d.wlane0) begin
          d.edge_sel = d.wdata[NEXT-1:0];
        end
      end else if (!hit(d.awaddr, OFF_STATUS)) begin
        wr_ok = 1'b0;
      end
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rsp.bvalid && axi_req_in.bready) begin
      d.rsp.bvalid  = 1'b0;
      d.rsp.awready = 1'b1;
      d.rsp.wready  = 1'b1;
    end

    // an event in the clearing cycle survives
    d.flag = (q.flag & ~clr) | ev;

    // register reads
    if (hit(axi_req_in.araddr, OFF_RESET_CTRL)) begin
      rd[BIT_PRIO_EN] = q.priority_levels_enable;
    end else if (hit(axi_req_in.araddr, OFF_INT_CTRL)) begin
      rd[BIT_GIE_H] = q.high_level_global_enable;
      rd[BIT_GIE_L] = q.low_level_global_enable;
    end else if (hit(axi_req_in.araddr, OFF_FLAGS)) begin
      rd = q.flag;
    end else if (hit(axi_req_in.araddr, OFF_ENABLES)) begin
      rd = q.en;
    end else if (hit(axi_req_in.araddr, OFF_PRIORITY)) begin
      rd = q.pri;
    end else if (hit(axi_req_in.araddr, OFF_EDGE)) begin
      rd[NEXT-1:0] = q.edge_sel;
    end else if (hit(axi_req_in.araddr, OFF_STATUS)) begin
      rd[5:0] = {q.st, q.hi_act, q.lo_act, q.req, q.vec_hi};
    end else begin
      rd_ok = 1'b0;
    end
    if (axi_req_in.arvalid && q.rsp.arready) begin
      d.rsp.arready = 1'b0;
      d.rsp.rvalid  = 1'b1;
      d.rsp.rdata   = {24'h00_0000, rd};
      d.rsp.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (q.rsp.rvalid && axi_req_in.rready) begin
      d.rsp.rvalid  = 1'b0;
      d.rsp.arready = 1'b1;
    end

    // vector request toward the core
    case (q.st)
      ST_IDLE: begin
        if (hi_pend || lo_pend) begin
          d.st     = ST_REQ;
          d.req    = 1'b1;
          d.vec_hi = hi_pend;
          d.vec    = hi_pend ? VEC_HIGH : VEC_LOW;
        end
      end
      ST_REQ: begin
        if (core_ack_in) begin
          d.st  = ST_IDLE;
          d.req = 1'b0;
          if (!q.priority_levels_enable || q.vec_hi) begin
            d.high_level_global_enable = 1'b0;
            d.hi_act                   = 1'b1;
          end else begin
            d.low_level_global_enable = 1'b0;
            d.lo_act                  = 1'b1;
          end
        end else if (!(hi_pend || lo_pend)) begin
          d.st  = ST_IDLE;
          d.req = 1'b0;
        end else begin
          d.vec_hi = hi_pend;
          d.vec    = hi_pend ? VEC_HIGH : VEC_LOW;
        end
      end
      default: begin
        d.st  = ST_IDLE;
        d.req = 1'b0;
      end
    endcase

    // return op restores the enable cleared on entry
    if (return_op_in) begin
      if (!q.priority_levels_enable || q.hi_act) begin
        d.high_level_global_enable = 1'b1;
        d.hi_act                   = 1'b0;
      end else if (q.lo_act) begin
        d.low_level_global_enable = 1'b1;
        d.lo_act                  = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      q             <= '0;
      q.st          <= ST_IDLE;
      q.pri         <= RST_PRIO;
      q.edge_sel    <= RST_EDGE;
      q.vec         <= VEC_HIGH;
      q.rsp.awready <= 1'b1;
      q.rsp.wready  <= 1'b1;
      q.rsp.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign axi_rsp_out = q.rsp;
  assign irq_req_out = q.req;
  assign vector_out  = q.vec;
  assign wake_out    = q.wake;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  property p_compat_vec;
    irq_req_out && !q.priority_levels_enable |-> vector_out == VEC_HIGH;
  endproperty
  a_compat_vec: assert property (p_compat_vec) else $error("compat vector wrong");

  property p_low_vec;
    irq_req_out && !q.vec_hi |-> vector_out == VEC_LOW && !q.hi_act;
  endproperty
  a_low_vec: assert property (p_low_vec) else $error("low vector wrong");

  property p_ack_clears;
    irq_req_out && core_ack_in && !return_op_in && (q.vec_hi || !q.priority_levels_enable)
      |=> !q.high_level_global_enable && q.hi_act && !irq_req_out;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("enable not cleared");

  property p_return_sets;
    return_op_in && !q.priority_levels_enable && !core_ack_in
      |=> q.high_level_global_enable && !q.hi_act;
  endproperty
  a_return_sets: assert property (p_return_sets) else $error("enable not restored");

  property p_flag_set;
    periph_event_in[0] |=> q.flag[NEXT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_rise_edge;
    q.edge_sel[0] && !q.pin_prev[0] && ext_pin_in[0] |=> q.flag[0];
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("edge missed");

  property p_dispatch;
    q.st == ST_IDLE && (hi_pend || lo_pend) |=> irq_req_out ##0 q.st == ST_REQ;
  endproperty
  a_dispatch: assert property (p_dispatch) else $error("request not raised");

  property p_pin_latency;
    q.st == ST_IDLE && q.edge_sel[0] && !q.pin_prev[0] && ext_pin_in[0] && q.en[0]
      && q.high_level_global_enable && !q.priority_levels_enable && !core_ack_in
      && !return_op_in && !q.rsp.bvalid && !d.rsp.bvalid && !hi_pend
      ##1 !d.rsp.bvalid |=> irq_req_out;
  endproperty
  a_pin_latency: assert property (p_pin_latency) else $error("pin latency");

  property p_preempt;
    q.st == ST_IDLE && q.lo_act && hi_pend |=> irq_req_out && vector_out == VEC_HIGH;
  endproperty
  a_preempt: assert property (p_preempt) else $error("no preemption");

  property p_wake;
    |(q.flag & q.en) |=> wake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missing");

  property p_high_vec;
    irq_req_out && q.vec_hi |-> vector_out == VEC_HIGH;
  endproperty
  a_high_vec: assert property (p_high_vec) else $error("high vector wrong");

  property p_enable_gate;
    q.st == ST_IDLE && !(|(q.flag & q.en)) |=> !irq_req_out;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("gated source fired");

  property p_high_gate;
    q.st == ST_IDLE && q.priority_levels_enable && !q.high_level_global_enable
      |=> !irq_req_out;
  endproperty
  a_high_gate: assert property (p_high_gate) else $error("high gate");

  property p_low_gate;
    q.st == ST_IDLE && q.priority_levels_enable && !q.low_level_global_enable
      && !(|(q.flag & q.en & q.pri)) |=> !irq_req_out;
  endproperty
  a_low_gate: assert property (p_low_gate) else $error("low gate");

  property p_periph_gate;
    q.st == ST_IDLE && !q.priority_levels_enable && !q.low_level_global_enable
      && !(|(q.flag & q.en & ~PERIPH_MASK)) |=> !irq_req_out;
  endproperty
  a_periph_gate: assert property (p_periph_gate) else $error("peripheral gate");

  property p_upgrade;
    q.st == ST_REQ && !core_ack_in && hi_pend |=> irq_req_out && vector_out == VEC_HIGH;
  endproperty
  a_upgrade: assert property (p_upgrade) else $error("no upgrade");

  property p_low_clears;
    irq_req_out && core_ack_in && !return_op_in && q.priority_levels_enable && !q.vec_hi
      |=> !q.low_level_global_enable && q.lo_act && !irq_req_out;
  endproperty
  a_low_clears: assert property (p_low_clears) else $error("low enable kept");

  property p_low_return;
    return_op_in && q.priority_levels_enable && !q.hi_act && q.lo_act && !core_ack_in
      |=> q.low_level_global_enable && !q.lo_act;
  endproperty
  a_low_return: assert property (p_low_return) else $error("low not restored");

  property p_low_blocked;
    q.st == ST_IDLE && q.priority_levels_enable && q.hi_act
      && !(|(q.flag & q.en & q.pri)) |=> !irq_req_out;
  endproperty
  a_low_blocked: assert property (p_low_blocked) else $error("low during high");

endmodule // two_level_intc

// ---- tb/core_model.sv ----
/*
  core-side partner: takes vector requests after a set delay and issues return ops.
  assumes the controller's clock and reset; the bench commands each return.
*/
`timescale 1ns/1ps
module core_model (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        irq_req_in,
  input  wire logic [15:0] vector_in,
  input  wire logic [3:0]  delay_in,
  input  wire logic        ret_cmd_in,
  output logic             ack_out,
  output logic             return_op_out,
  output logic [15:0]      last_vector_out
);
  logic [3:0] wait_q;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out         <= 1'b0;
      return_op_out   <= 1'b0;
      last_vector_out <= 16'h0000;
      wait_q          <= 4'h0;
    end else begin
      ack_out       <= 1'b0;
      // bench clears the serviced flags before it commands a return
      return_op_out <= ret_cmd_in;
      if (irq_req_in && !ack_out) begin
        if (wait_q == delay_in) begin
          ack_out         <= 1'b1;
          last_vector_out <= vector_in;
          wait_q          <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end else begin
        wait_q <= 4'h0;
      end
    end
  end
endmodule // core_model

// ---- tb/testbench.sv ----
/*
  self-checking bench: AXI4-Lite register access, pin and peripheral events, core model.
  assumes the controller package and one 40 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  import intc_pkg::*;
  logic            clock_in;
  logic            rst_in;
  axi_req_t        req;
  axi_rsp_t        rsp;
  logic [NEXT-1:0] pins;
  logic [NEXT-1:0] events;
  logic            ret_cmd;
  logic [3:0]      delay;
  logic            ack;
  logic            ret_op;
  logic            irq;
  logic            wake;
  logic [15:0]     vec;
  logic [15:0]     last_vec;
  int              fails;
  int              comparisons;
  int              lat;

  two_level_intc dut (.clock_in(clock_in), .rst_in(rst_in), .axi_req_in(req),
    .axi_rsp_out(rsp), .ext_pin_in(pins), .periph_event_in(events), .core_ack_in(ack),
    .return_op_in(ret_op), .irq_req_out(irq), .vector_out(vec), .wake_out(wake));
  core_model core (.clock_in(clock_in), .rst_in(rst_in), .irq_req_in(irq), .vector_in(vec),
    .delay_in(delay), .ret_cmd_in(ret_cmd), .ack_out(ack), .return_op_out(ret_op),
    .last_vector_out(last_vec));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clock_in);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    // one plain word write per register, never a memory-to-memory move
    while (!done) begin
      @(posedge clock_in);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        req.bready <= 1'b0;
        check(32'(rsp.bresp), 32'(er));
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed);
    logic done;
    done = 1'b0;
    @(posedge clock_in);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    while (!done) begin
      @(posedge clock_in);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        req.rready <= 1'b0;
        check(rsp.rdata, ed);
        check(32'(rsp.rresp), 32'(RESP_OKAY));
        done = 1'b1;
      end
    end
  endtask

  task automatic wait_irq(input logic [15:0] ev);
    lat = 0;
    while (irq !== 1'b1 && lat < 40) begin
      @(posedge clock_in);
      lat++;
    end
    check(32'(irq), 32'h1);
    check(32'(vec), 32'(ev));
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clock_in);
      check(32'(irq), 32'h0);
    end
  endtask

  task automatic set_pins(input logic [NEXT-1:0] v);
    @(posedge clock_in);
    pins <= v;
  endtask

  task automatic pulse_event();
    @(posedge clock_in);
    events <= 4'h1;
    @(posedge clock_in);
    events <= 4'h0;
  endtask

  task automatic do_return();
    @(posedge clock_in);
    ret_cmd <= 1'b1;
    @(posedge clock_in);
    ret_cmd <= 1'b0;
    repeat (3) @(posedge clock_in);
  endtask

  task automatic results();
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  initial begin
    #500000;
    fails++;
    results();
  end

  initial begin
    req = '0;
    pins = 4'h0;
    events = 4'h0;
    ret_cmd = 1'b0;
    delay = 4'h0;
    rst_in = 1'b1;
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(OFF_RESET_CTRL, 32'h0);
    rd(OFF_INT_CTRL, 32'h0);
    rd(OFF_PRIORITY, 32'hFF);
    rd(OFF_EDGE, 32'hF);
    wr(8'h1C, 32'h0, RESP_SLVERR);
    set_pins(4'h1);
    pulse_event();
    rd(OFF_FLAGS, 32'h11);
    quiet(2);
    check(32'(wake), 32'h0);
    wr(OFF_EDGE, 32'hE, RESP_OKAY);
    wr(OFF_FLAGS, 32'h11, RESP_OKAY);
    set_pins(4'h0);
    rd(OFF_FLAGS, 32'h01);
    wr(OFF_EDGE, 32'hF, RESP_OKAY);
    wr(OFF_FLAGS, 32'h01, RESP_OKAY);
    wr(OFF_ENABLES, 32'h11, RESP_OKAY);
    wr(OFF_PRIORITY, 32'h00, RESP_OKAY);
    wr(OFF_INT_CTRL, 32'h80, RESP_OKAY);
    pulse_event();
    quiet(4);
    check(32'(wake), 32'h1);
    set_pins(4'h1);
    wait_irq(VEC_HIGH);
    check(32'(lat), 32'h3);
    repeat (3) @(posedge clock_in);
    check(32'(last_vec), 32'(VEC_HIGH));
    rd(OFF_INT_CTRL, 32'h00);
    wr(OFF_FLAGS, 32'h11, RESP_OKAY);
    do_return();
    rd(OFF_INT_CTRL, 32'h80);
    wr(OFF_INT_CTRL, 32'hC0, RESP_OKAY);
    pulse_event();
    wait_irq(VEC_HIGH);
    repeat (3) @(posedge clock_in);
    wr(OFF_FLAGS, 32'h10, RESP_OKAY);
    do_return();
    set_pins(4'h0);
    wr(OFF_RESET_CTRL, 32'h80, RESP_OKAY);
    wr(OFF_PRIORITY, 32'h01, RESP_OKAY);
    wr(OFF_INT_CTRL, 32'h80, RESP_OKAY);
    pulse_event();
    quiet(4);
    wr(OFF_INT_CTRL, 32'hC0, RESP_OKAY);
    wait_irq(VEC_LOW);
    repeat (3) @(posedge clock_in);
    rd(OFF_INT_CTRL, 32'h80);
    delay <= 4'h5;
    set_pins(4'h1);
    wait_irq(VEC_HIGH);
    repeat (3) @(posedge clock_in);
    check(32'(irq), 32'h1);
    repeat (6) @(posedge clock_in);
    rd(OFF_INT_CTRL, 32'h00);
    wr(OFF_FLAGS, 32'h11, RESP_OKAY);
    // the only in-service re-enable, made on purpose to probe the low lockout
    wr(OFF_INT_CTRL, 32'hC0, RESP_OKAY);
    pulse_event();
    quiet(5);
    wr(OFF_FLAGS, 32'h10, RESP_OKAY);
    do_return();
    rd(OFF_STATUS, 32'h15);
    do_return();
    rd(OFF_STATUS, 32'h11);
    results();
  end
endmodule // testbench
